// file: inc/cpm_pkg.sv
// Constants and carrier types for the call-progress monitor gain block.
// Assumes a single 250 MHz clock domain and an AXI4-Lite register slave.
`default_nettype none

package cpm_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int SAMPLE_W   = 16;   // Signed path sample width
  localparam int CODE_W     = 8;    // Gain code width
  localparam int UNITY_SH   = 6;    // Unity code 64 is two to the sixth
  localparam int PROD_W     = SAMPLE_W + CODE_W + 1;
  localparam int SCALED_W   = PROD_W - UNITY_SH;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;

  localparam logic [CODE_W-1:0] GAIN_UNITY = 8'h40;
  localparam logic [CODE_W-1:0] GAIN_MUTE  = 8'h00;

  // ---------------------------------------------------------------
  // Register indices, byte addresses and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RX_GAIN_IDX   = 8'h14;
  localparam logic [7:0] TX_GAIN_IDX   = 8'h15;
  localparam logic [7:0] RING_CTL1_IDX = 8'h16;

  localparam logic [ADDR_W-1:0] RX_GAIN_ADDR   = {RX_GAIN_IDX[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] TX_GAIN_ADDR   = {TX_GAIN_IDX[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] RING_CTL1_ADDR = {RING_CTL1_IDX[5:0], 2'b00};

  localparam logic [7:0] RX_GAIN_RST   = 8'h00;
  localparam logic [7:0] TX_GAIN_RST   = 8'h00;
  localparam logic [7:0] RING_CTL1_RST = 8'h96;

  // Ring control one field positions
  localparam int RING_DLY_LSB = 6;
  localparam int RING_DLY_W   = 2;
  localparam int RING_MAX_LSB = 0;
  localparam int RING_MAX_W   = 6;

  // ---------------------------------------------------------------
  // Bus responses
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                       valid;
    logic signed [SAMPLE_W-1:0] data;
  } cpm_sample_t;

  typedef struct packed {
    logic                       valid;
    logic signed [SCALED_W-1:0] data;
  } cpm_scaled_t;

endpackage : cpm_pkg

`default_nettype wire

// file: hdl/cpm_gain_path.sv
// One monitor path: scales a signed sample by code/64, zero code mutes.
// Assumes samples arrive synchronous to clk with a one-cycle valid strobe.
`timescale 1ns/1ps
`default_nettype none

module cpm_gain_path (
  input  wire logic                              clk,
  input  wire logic                              srst,
  input  wire cpm_pkg::cpm_sample_t              in_s,
  input  wire logic [cpm_pkg::CODE_W-1:0]        gain_code,
  output var cpm_pkg::cpm_scaled_t               out_s
);

  logic signed [cpm_pkg::PROD_W-1:0] prod;
  cpm_pkg::cpm_scaled_t              out_r;
  cpm_pkg::cpm_scaled_t              out_nxt;

  // Linear product, then divide by the unity code with an arithmetic shift
  always_comb begin
    prod          = $signed(in_s.data) * $signed({1'b0, gain_code});
    out_nxt.valid = in_s.valid;
    out_nxt.data  = '0;
    if (in_s.valid && gain_code != cpm_pkg::GAIN_MUTE) begin
      out_nxt.data = prod[cpm_pkg::PROD_W-1:cpm_pkg::UNITY_SH];
    end
  end

  // Output stage
  always_ff @(posedge clk) begin
    if (srst) begin
      out_r <= '0;
    end else begin
      out_r <= out_nxt;
    end
  end

  assign out_s = out_r;

endmodule : cpm_gain_path

`default_nettype wire

// file: hdl/cpm_monitor_top.sv
// Call-progress monitor gain stage with AXI4-Lite control registers.
// Assumes one clock, synchronous active-high reset, AXI4-Lite master that
// keeps one write and one read outstanding at most.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none

module cpm_monitor_top (
  input  wire logic                             clk,
  input  wire logic                             srst,
  // AXI4-Lite slave
  input  wire logic [cpm_pkg::ADDR_W-1:0]       s_axi_awaddr,
  input  wire logic                             s_axi_awvalid,
  output logic                                  s_axi_awready,
  input  wire logic [cpm_pkg::DATA_W-1:0]       s_axi_wdata,
  input  wire logic [3:0]                       s_axi_wstrb,
  input  wire logic                             s_axi_wvalid,
  output logic                                  s_axi_wready,
  output logic [1:0]                            s_axi_bresp,
  output logic                                  s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  input  wire logic [cpm_pkg::ADDR_W-1:0]       s_axi_araddr,
  input  wire logic                             s_axi_arvalid,
  output logic                                  s_axi_arready,
  output logic [cpm_pkg::DATA_W-1:0]            s_axi_rdata,
  output logic [1:0]                            s_axi_rresp,
  output logic                                  s_axi_rvalid,
  input  wire logic                             s_axi_rready,
  // Monitor paths
  input  wire cpm_pkg::cpm_sample_t             rx_in,
  input  wire cpm_pkg::cpm_sample_t             tx_in,
  output var cpm_pkg::cpm_sample_t              monitor_output,
  // Ring validation settings for the ring logic
  output logic [cpm_pkg::RING_DLY_W-1:0]        ring_report_delay,
  output logic [cpm_pkg::RING_MAX_W-1:0]        ring_interval_max
);

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [7:0]                    rx_gain_r, rx_gain_nxt;
  logic [7:0]                    tx_gain_r, tx_gain_nxt;
  logic [7:0]                    ring_r, ring_nxt;
  logic                          aw_have_r, aw_have_nxt;
  logic                          w_have_r, w_have_nxt;
  logic [cpm_pkg::ADDR_W-1:0]    awaddr_r, awaddr_nxt;
  logic [7:0]                    wdata_r, wdata_nxt;
  logic                          wstrb_r, wstrb_nxt;
  logic                          awready_r, awready_nxt;
  logic                          wready_r, wready_nxt;
  logic                          bvalid_r, bvalid_nxt;
  logic [1:0]                    bresp_r, bresp_nxt;
  logic                          arready_r, arready_nxt;
  logic                          rvalid_r, rvalid_nxt;
  logic [1:0]                    rresp_r, rresp_nxt;
  logic [cpm_pkg::DATA_W-1:0]    rdata_r, rdata_nxt;

  logic                          aw_fire, w_fire, ar_fire, commit;
  logic [cpm_pkg::ADDR_W-1:0]    wr_addr;
  logic [7:0]                    wr_byte;
  logic                          wr_lane;

  assign aw_fire = s_axi_awvalid && awready_r;
  assign w_fire  = s_axi_wvalid && wready_r;
  assign ar_fire = s_axi_arvalid && arready_r;

  // Write channel: address and data taken in either order, response after both
  always_comb begin
    wr_addr     = aw_have_r ? awaddr_r : s_axi_awaddr;
    wr_byte     = w_have_r ? wdata_r : s_axi_wdata[7:0];
    wr_lane     = w_have_r ? wstrb_r : s_axi_wstrb[0];
    commit      = (aw_have_r || aw_fire) && (w_have_r || w_fire) && !bvalid_r;
    aw_have_nxt = (aw_have_r || aw_fire) && !commit;
    w_have_nxt  = (w_have_r || w_fire) && !commit;
    awaddr_nxt  = aw_fire ? s_axi_awaddr : awaddr_r;
    wdata_nxt   = w_fire ? s_axi_wdata[7:0] : wdata_r;
    wstrb_nxt   = w_fire ? s_axi_wstrb[0] : wstrb_r;
    bvalid_nxt  = commit || (bvalid_r && !s_axi_bready);
    bresp_nxt   = bresp_r;
    awready_nxt = !aw_have_nxt && !bvalid_nxt;
    wready_nxt  = !w_have_nxt && !bvalid_nxt;
    rx_gain_nxt = rx_gain_r;
    tx_gain_nxt = tx_gain_r;
    ring_nxt    = ring_r;
    if (commit) begin
      bresp_nxt = cpm_pkg::RESP_OKAY;
      if (wr_addr == cpm_pkg::RX_GAIN_ADDR) begin
        if (wr_lane) rx_gain_nxt = wr_byte;
      end else if (wr_addr == cpm_pkg::TX_GAIN_ADDR) begin
        if (wr_lane) tx_gain_nxt = wr_byte;
      end else if (wr_addr == cpm_pkg::RING_CTL1_ADDR) begin
        if (wr_lane) ring_nxt = wr_byte;
      end else begin
        bresp_nxt = cpm_pkg::RESP_SLVERR;                  // Unmapped address
      end
    end
  end

  // Read channel: one read outstanding, data held until taken
  always_comb begin
    rvalid_nxt  = ar_fire || (rvalid_r && !s_axi_rready);
    arready_nxt = !rvalid_nxt;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (ar_fire) begin
      rresp_nxt = cpm_pkg::RESP_OKAY;
      if (s_axi_araddr == cpm_pkg::RX_GAIN_ADDR) begin
        rdata_nxt = {24'h000000, rx_gain_r};
      end else if (s_axi_araddr == cpm_pkg::TX_GAIN_ADDR) begin
        rdata_nxt = {24'h000000, tx_gain_r};
      end else if (s_axi_araddr == cpm_pkg::RING_CTL1_ADDR) begin
        rdata_nxt = {24'h000000, ring_r};
      end else begin
        rdata_nxt = 32'h00000000;
        rresp_nxt = cpm_pkg::RESP_SLVERR;
      end
    end
  end

  // Register bank and bus handshake flops
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_gain_r <= cpm_pkg::RX_GAIN_RST;
      tx_gain_r <= cpm_pkg::TX_GAIN_RST;
      ring_r    <= cpm_pkg::RING_CTL1_RST;
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= 8'h00;
      wstrb_r   <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= cpm_pkg::RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rresp_r   <= cpm_pkg::RESP_OKAY;
      rdata_r   <= 32'h00000000;
    end else begin
      rx_gain_r <= rx_gain_nxt;
      tx_gain_r <= tx_gain_nxt;
      ring_r    <= ring_nxt;
      aw_have_r <= aw_have_nxt;
      w_have_r  <= w_have_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  assign s_axi_awready     = awready_r;
  assign s_axi_wready      = wready_r;
  assign s_axi_bvalid      = bvalid_r;
  assign s_axi_bresp       = bresp_r;
  assign s_axi_arready     = arready_r;
  assign s_axi_rvalid      = rvalid_r;
  assign s_axi_rresp       = rresp_r;
  assign s_axi_rdata       = rdata_r;
  assign ring_report_delay = ring_r[cpm_pkg::RING_DLY_LSB +: cpm_pkg::RING_DLY_W];
  assign ring_interval_max = ring_r[cpm_pkg::RING_MAX_LSB +: cpm_pkg::RING_MAX_W];

  // ---------------------------------------------------------------
  // Monitor paths
  // ---------------------------------------------------------------
  cpm_pkg::cpm_scaled_t rx_scaled;
  cpm_pkg::cpm_scaled_t tx_scaled;

  // Receive path gain, code used live
  cpm_gain_path u_rx_path (
    .clk       (clk),
    .srst      (srst),
    .in_s      (rx_in),
    .gain_code (rx_gain_r),
    .out_s     (rx_scaled)
  );

  // Transmit path gain, code used live
  cpm_gain_path u_tx_path (
    .clk       (clk),
    .srst      (srst),
    .in_s      (tx_in),
    .gain_code (tx_gain_r),
    .out_s     (tx_scaled)
  );

  localparam int SUM_W = cpm_pkg::SCALED_W + 1;
  localparam logic signed [SUM_W-1:0] SAT_HI = SUM_W'(32767);
  localparam logic signed [SUM_W-1:0] SAT_LO = -SUM_W'(32768);

  logic signed [SUM_W-1:0] mix_sum;
  cpm_pkg::cpm_sample_t    mon_r, mon_nxt;

  // Mix both paths and saturate to the sample range
  always_comb begin
    mix_sum       = SUM_W'(rx_scaled.data) + SUM_W'(tx_scaled.data);
    mon_nxt.valid = rx_scaled.valid || tx_scaled.valid;
    if (mix_sum > SAT_HI) begin
      mon_nxt.data = 16'h7FFF;
    end else if (mix_sum < SAT_LO) begin
      mon_nxt.data = 16'h8000;
    end else begin
      mon_nxt.data = mix_sum[cpm_pkg::SAMPLE_W-1:0];
    end
  end

  // Output stage of the mixer
  always_ff @(posedge clk) begin
    if (srst) begin
      mon_r <= '0;
    end else begin
      mon_r <= mon_nxt;
    end
  end

  assign monitor_output = mon_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  logic signed [cpm_pkg::PROD_W-1:0] rx_exp, tx_exp;
  assign rx_exp = $signed(rx_in.data) * $signed({1'b0, rx_gain_r});
  assign tx_exp = $signed(tx_in.data) * $signed({1'b0, tx_gain_r});

  sequence rx_wr_s;
    aw_fire && w_fire && s_axi_awaddr == cpm_pkg::RX_GAIN_ADDR && s_axi_wstrb[0];
  endsequence

  sequence rx_rd_s;
    ar_fire && s_axi_araddr == cpm_pkg::RX_GAIN_ADDR;
  endsequence

  rx_scale_a: assert property (rx_in.valid |=> rx_scaled.valid &&
    rx_scaled.data == $past(rx_exp >>> cpm_pkg::UNITY_SH))
    else $error("receive path scaling wrong");
  rx_mute_a: assert property (rx_in.valid && rx_gain_r == 8'h00 |=>
    rx_scaled.data == '0)
    else $error("receive path not muted");
  tx_scale_a: assert property (tx_in.valid |=> tx_scaled.valid &&
    tx_scaled.data == $past(tx_exp >>> cpm_pkg::UNITY_SH))
    else $error("transmit path scaling wrong");
  tx_mute_a: assert property (tx_in.valid && tx_gain_r == 8'h00 |=>
    tx_scaled.data == '0)
    else $error("transmit path not muted");
  gain_reset_a: assert property ($past(srst) |->
    rx_gain_r == 8'h00 && tx_gain_r == 8'h00 && !monitor_output.valid)
    else $error("gain codes not zero after reset");
  ring_reset_a: assert property ($past(srst) |-> ring_report_delay == 2'h2 &&
    ring_interval_max == 6'h16)
    else $error("ring control one reset value wrong");
  gain_write_a: assert property (rx_wr_s |=> rx_gain_r == $past(s_axi_wdata[7:0])
    && s_axi_bvalid)
    else $error("receive gain write not applied");
  gain_read_a: assert property (rx_rd_s |=> s_axi_rvalid &&
    s_axi_rdata == {24'h000000, $past(rx_gain_r)})
    else $error("receive gain readback wrong");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");

endmodule : cpm_monitor_top

`default_nettype wire

// file: bench/cpm_monitor_top_tb.sv
// Self-checking bench for the call-progress monitor gain stage.
// Assumes cpm_pkg is compiled first; drives the AXI4-Lite slave and both paths.
`timescale 1ns/1ps
`default_nettype none

module cpm_monitor_top_tb;
  logic                       clk, srst;
  logic [cpm_pkg::ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic                       s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [cpm_pkg::DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]                 s_axi_wstrb;
  logic [1:0]                 s_axi_bresp, s_axi_rresp;
  logic                       s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                       s_axi_rvalid, s_axi_rready;
  cpm_pkg::cpm_sample_t       rx_in, tx_in, monitor_output;
  logic [1:0]                 ring_report_delay;
  logic [5:0]                 ring_interval_max;
  int                         failures, compares;
  int                         b_wait;
  logic [7:0]                 codes [7] = '{8'hFF, 8'h7F, 8'h40, 8'h20, 8'h10, 8'h01, 8'h00};

  cpm_monitor_top cpm_monitor_top_i (
    .clk(clk), .srst(srst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .rx_in(rx_in), .tx_in(tx_in), .monitor_output(monitor_output),
    .ring_report_delay(ring_report_delay), .ring_interval_max(ring_interval_max)
  );

  // ---------------------------------------------------------------
  // Clock, verdict and watchdog
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic close_out;
    if (failures == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  // Cuts a hung handshake short
  initial begin
    #(20000 * 4);
    failures++;
    close_out();
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // ---------------------------------------------------------------
  // Bus tasks: ready and answer seen at the falling edge, acted on at rising
  // ---------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    logic aw_d, w_d, a_now, w_now;
    logic [1:0] r;
    aw_d = 1'b0;
    w_d  = 1'b0;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= (b_wait == 0);
    while (!(aw_d && w_d)) begin
      @(negedge clk);
      a_now = s_axi_awvalid && s_axi_awready === 1'b1;
      w_now = s_axi_wvalid && s_axi_wready === 1'b1;
      @(posedge clk);
      if (a_now) begin
        s_axi_awvalid <= 1'b0;
        aw_d = 1'b1;
      end
      if (w_now) begin
        s_axi_wvalid <= 1'b0;
        w_d = 1'b1;
      end
    end
    // Late response acceptance: bvalid must stand while bready is low
    if (b_wait > 0) begin
      repeat (b_wait) @(negedge clk);
      chk("bvalid_hold", {31'h0, s_axi_bvalid}, 32'h1);
      @(posedge clk);
      s_axi_bready <= 1'b1;
    end
    do @(negedge clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    @(posedge clk);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, r}, {30'h0, er});
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(negedge clk); while (s_axi_arready !== 1'b1);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge clk);
    s_axi_rready <= 1'b0;
    chk("rdata", d, ed);
    chk("rresp", {30'h0, r}, {30'h0, er});
  endtask : axi_rd

  // ---------------------------------------------------------------
  // Path tasks: model scale, floor shift, sum and saturate
  // ---------------------------------------------------------------
  function automatic logic [15:0] mix(input int r, input int rc, input int t, input int tc);
    int s;
    s = ((r * rc) >>> 6) + ((t * tc) >>> 6);
    if (s > 32767) s = 32767;
    if (s < -32768) s = -32768;
    return s[15:0];
  endfunction : mix

  // One strobe on each chosen path, result two cycles on, one cycle wide
  task automatic send(input logic rv, input logic [15:0] rd, input logic tv,
                      input logic [15:0] td, input logic [15:0] exp);
    @(posedge clk);
    rx_in <= '{valid: rv, data: rd};
    tx_in <= '{valid: tv, data: td};
    @(posedge clk);
    rx_in.valid <= 1'b0;
    tx_in.valid <= 1'b0;
    @(posedge clk);
    #1;
    chk("mon_valid", {31'h0, monitor_output.valid}, 32'h1);
    chk("mon_data", {16'h0, monitor_output.data}, {16'h0, exp});
    @(posedge clk);
    #1;
    chk("mon_drop", {31'h0, monitor_output.valid}, 32'h0);
  endtask : send

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    axi_rd(cpm_pkg::RX_GAIN_ADDR, 32'h00, cpm_pkg::RESP_OKAY);
    axi_rd(cpm_pkg::TX_GAIN_ADDR, 32'h00, cpm_pkg::RESP_OKAY);
    axi_rd(cpm_pkg::RING_CTL1_ADDR, 32'h96, cpm_pkg::RESP_OKAY);
    chk("ring_dly", {30'h0, ring_report_delay}, 32'h2);
    chk("ring_max", {26'h0, ring_interval_max}, 32'h16);
    send(1'b1, 16'h7FFF, 1'b1, 16'h8000, 16'h0000);
  endtask : t_reset

  task automatic t_codes;
    foreach (codes[i]) begin
      axi_wr(cpm_pkg::RX_GAIN_ADDR, {24'h0, codes[i]}, 4'h1, cpm_pkg::RESP_OKAY);
      axi_wr(cpm_pkg::TX_GAIN_ADDR, 32'h40, 4'h1, cpm_pkg::RESP_OKAY);
      axi_rd(cpm_pkg::RX_GAIN_ADDR, {24'h0, codes[i]}, cpm_pkg::RESP_OKAY);
      send(1'b1, 16'hFC18, 1'b0, 16'h1234, mix(-1000, codes[i], 0, 0));
      axi_wr(cpm_pkg::RX_GAIN_ADDR, 32'h00, 4'h1, cpm_pkg::RESP_OKAY);
      axi_wr(cpm_pkg::TX_GAIN_ADDR, {24'h0, codes[i]}, 4'h1, cpm_pkg::RESP_OKAY);
      axi_rd(cpm_pkg::TX_GAIN_ADDR, {24'h0, codes[i]}, cpm_pkg::RESP_OKAY);
      send(1'b1, 16'h7FFF, 1'b1, 16'h1234, mix(0, 0, 4660, codes[i]));
    end
  endtask : t_codes

  task automatic t_sum;
    axi_wr(cpm_pkg::RX_GAIN_ADDR, 32'hFF, 4'h1, cpm_pkg::RESP_OKAY);
    axi_wr(cpm_pkg::TX_GAIN_ADDR, 32'hFF, 4'h1, cpm_pkg::RESP_OKAY);
    send(1'b1, 16'h7FFF, 1'b1, 16'h7FFF, 16'h7FFF);
    send(1'b1, 16'h8000, 1'b1, 16'h8000, 16'h8000);
    send(1'b1, 16'h0100, 1'b1, 16'hFF00, mix(256, 255, -256, 255));
  endtask : t_sum

  task automatic t_ring_bus;
    axi_wr(cpm_pkg::RING_CTL1_ADDR, 32'h5A, 4'h1, cpm_pkg::RESP_OKAY);
    axi_rd(cpm_pkg::RING_CTL1_ADDR, 32'h5A, cpm_pkg::RESP_OKAY);
    chk("ring_dly", {30'h0, ring_report_delay}, 32'h1);
    chk("ring_max", {26'h0, ring_interval_max}, 32'h1A);
    axi_wr(8'hFC, 32'h33, 4'h1, cpm_pkg::RESP_SLVERR);
    axi_rd(8'hFC, 32'h00, cpm_pkg::RESP_SLVERR);
    axi_wr(cpm_pkg::RX_GAIN_ADDR, 32'h11, 4'h0, cpm_pkg::RESP_OKAY);
    axi_rd(cpm_pkg::RX_GAIN_ADDR, 32'hFF, cpm_pkg::RESP_OKAY);
    b_wait = 3;
    axi_wr(cpm_pkg::TX_GAIN_ADDR, 32'h25, 4'h1, cpm_pkg::RESP_OKAY);
    b_wait = 0;
    axi_rd(cpm_pkg::TX_GAIN_ADDR, 32'h25, cpm_pkg::RESP_OKAY);
  endtask : t_ring_bus

  // Main sequence
  initial begin
    failures = 0;
    compares = 0;
    b_wait = 0;
    srst = 1'b1;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    rx_in = '0;
    tx_in = '0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_codes();
    t_sum();
    t_ring_bus();
    close_out();
  end
endmodule : cpm_monitor_top_tb

`default_nettype wire
